// File: design/sai_ms_timer.sv
// Millisecond tick generator for the slider acceleration block
module sai_ms_timer #(
	parameter int MsClocks = 40000
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic resetn,
	// Tick
	output logic      msTick
);
	import sai_pkg::*;

	logic [15:0] cnt_reg;
	logic [15:0] cnt_next;
	logic        tick_reg;
	logic        tick_next;

	always_comb
	begin
		tick_next = (cnt_reg == 16'(MsClocks - 1));
		cnt_next  = tick_next ? 16'h0000 : cnt_reg + 16'h0001;
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			cnt_reg  <= 16'h0000;
			tick_reg <= 1'b0;
		end
		else
		begin
			cnt_reg  <= cnt_next;
			tick_reg <= tick_next;
		end
	end

	assign msTick = tick_reg;

endmodule // sai_ms_timer

// File: design/sai_slider_accel.sv
// Slider acceleration: extra interrupts and speed scaled repeat interval
// How it works
// RULE_01: Bit 7 enables extra acceleration interrupts.
// RULE_02: Enable clear: no extra interrupts ever.
// RULE_03: Enabled by reset; count grows with speed.
// RULE_04: Bits 6-4 cap extras per slide.
// RULE_05: Count is limit, half, or one by time. Code gives one only for a limit of 4 or more, else none.
// RULE_06: Bits 3-2 window; slower slides earn none.
// RULE_07: Window 350, 560, 770 or 980 ms.
// RULE_08: Speed is sensors touched per 100 ms.
// RULE_09: Bits 1-0 choose repeat speed-up strength.
// RULE_10: Interval counts measurement cycles between interrupts.
// RULE_11: Interval table by sensor count and scale.
// RULE_12: Strongest scale keeps fixed 140/105/70 values.
// RULE_13: Extras share the ordinary slider interrupt path.
module sai_slider_accel #(
	parameter int MsClocks = sai_pkg::MS_CLOCKS
) (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       resetn,
	// Register port
	input  wire logic [7:0] regAddr,
	input  wire logic       regWrEn,
	input  wire logic [7:0] regWrData,
	input  wire logic       regRdEn,
	output logic [7:0]      regRdData,
	// Slider engine
	input  wire logic       measTick,
	input  wire logic       slideActive,
	input  wire logic       sensorStep,
	input  wire logic       slideIrqIn,
	input  wire logic [3:0] sliderRepeatInterval,
	// Results
	output logic            sliderIrq,
	output logic            extraIrq,
	output logic [2:0]      extraPending,
	output logic [3:0]      repeatInterval
);
	import sai_pkg::*;

	// ***************************************************
	// Timebase and speed measurement
	// ***************************************************
	logic       msTick;
	logic [2:0] speedCount;

	sai_ms_timer #(
		.MsClocks (MsClocks)
	) u_timer (
		.clk      (clk),
		.resetn   (resetn),
		.msTick   (msTick)
	);

	sai_speed_meter u_speed (
		.clk        (clk),
		.resetn     (resetn),
		.msTick     (msTick),
		.sensorStep (sensorStep),
		.speedCount (speedCount)
	);

	// ***************************************************
	// Configuration register
	// ***************************************************
	logic [7:0] cfg_reg;
	logic [7:0] cfg_next;
	logic [7:0] rd_reg;
	logic [7:0] rd_next;
	logic       accelEnable;
	logic [2:0] extraLimit;
	logic [1:0] windowSel;
	logic [1:0] repeatScale;

	always_comb
	begin
		cfg_next = cfg_reg;
		rd_next  = rd_reg;
		if (regWrEn && regAddr == CFG_ADDR)
			cfg_next = regWrData;
		if (regRdEn)
			rd_next = (regAddr == CFG_ADDR) ? cfg_reg : 8'h00;
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			cfg_reg <= CFG_RESET; // [RULE_03]
			rd_reg  <= 8'h00;
		end
		else
		begin
			cfg_reg <= cfg_next;
			rd_reg  <= rd_next;
		end
	end

	assign accelEnable = cfg_reg[ENABLE_BIT]; // [RULE_01]
	assign extraLimit  = cfg_reg[LIMIT_LSB +: 3]; // [RULE_04]
	assign windowSel   = cfg_reg[WINDOW_LSB +: 2]; // [RULE_06] [RULE_07]
	assign repeatScale = cfg_reg[SCALE_LSB +: 2]; // [RULE_09]
	assign regRdData   = rd_reg;

	// ***************************************************
	// Slide sequencing
	// ***************************************************
	sai_state_t state_reg;
	sai_state_t state_next;
	logic [9:0] slideMs_reg;
	logic [9:0] slideMs_next;
	logic [3:0] repCnt_reg;
	logic [3:0] repCnt_next;
	logic [2:0] extraLeft_reg;
	logic [2:0] extraLeft_next;
	logic       extraIrq_reg;
	logic       extraIrq_next;
	logic       sliderIrq_reg;
	logic       sliderIrq_next;
	logic [3:0] interval_reg;
	logic [3:0] interval_next;
	logic [3:0] intervalNow;
	logic [2:0] earned;

	always_comb
	begin
		intervalNow    = sai_repeat_cycles(speedCount, repeatScale, sliderRepeatInterval); // [RULE_11] [RULE_12]
		earned         = accelEnable ? sai_extra_count(slideMs_reg, windowSel, extraLimit) : 3'h0; // [RULE_05]
		state_next     = state_reg;
		slideMs_next   = slideMs_reg;
		repCnt_next    = repCnt_reg;
		extraLeft_next = extraLeft_reg;
		extraIrq_next  = 1'b0;
		interval_next  = intervalNow;
		case (state_reg)
			ST_IDLE:
			begin
				if (slideActive)
				begin
					state_next   = ST_SLIDE;
					slideMs_next = 10'h000;
					repCnt_next  = intervalNow;
				end
			end
			ST_SLIDE:
			begin
				if (msTick && slideMs_reg != SLIDE_MS_MAX)
					slideMs_next = slideMs_reg + 10'h001;
				if (!slideActive)
				begin
					extraLeft_next = earned; // [RULE_03] [RULE_04] [RULE_06]
					repCnt_next    = intervalNow;
					state_next     = (earned == 3'h0) ? ST_IDLE : ST_EXTRA;
				end
				else if (measTick)
				begin
					if (repCnt_reg <= 4'h1) // [RULE_10]
					begin
						extraIrq_next = accelEnable; // [RULE_02]
						repCnt_next   = intervalNow;
					end
					else
						repCnt_next = repCnt_reg - 4'h1;
				end
			end
			ST_EXTRA:
			begin
				if (!accelEnable) // [RULE_02]
				begin
					extraLeft_next = 3'h0;
					state_next     = ST_IDLE;
				end
				else if (slideActive)
				begin
					// A new slide drops leftovers of the previous one
					extraLeft_next = 3'h0;
					slideMs_next   = 10'h000;
					repCnt_next    = intervalNow;
					state_next     = ST_SLIDE;
				end
				else if (measTick)
				begin
					if (repCnt_reg <= 4'h1) // [RULE_10]
					begin
						extraIrq_next  = 1'b1;
						extraLeft_next = extraLeft_reg - 3'h1;
						repCnt_next    = intervalNow;
						if (extraLeft_reg == 3'h1)
							state_next = ST_IDLE;
					end
					else
						repCnt_next = repCnt_reg - 4'h1;
				end
			end
			default:
			begin
				state_next     = ST_IDLE;
				extraLeft_next = 3'h0;
			end
		endcase
		// One pulse per cycle on the shared interrupt path; an extra and an ordinary interrupt in one cycle merge into one pulse
		sliderIrq_next = extraIrq_next | slideIrqIn; // [RULE_13]
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_reg     <= ST_IDLE;
			slideMs_reg   <= 10'h000;
			repCnt_reg    <= 4'h0;
			extraLeft_reg <= 3'h0;
			extraIrq_reg  <= 1'b0;
			sliderIrq_reg <= 1'b0;
			interval_reg  <= 4'h0;
		end
		else
		begin
			state_reg     <= state_next;
			slideMs_reg   <= slideMs_next;
			repCnt_reg    <= repCnt_next;
			extraLeft_reg <= extraLeft_next;
			extraIrq_reg  <= extraIrq_next;
			sliderIrq_reg <= sliderIrq_next;
			interval_reg  <= interval_next;
		end
	end

	assign sliderIrq      = sliderIrq_reg;
	assign extraIrq       = extraIrq_reg;
	assign extraPending   = extraLeft_reg;
	assign repeatInterval = interval_reg;

	// ***************************************************
	// Checks
	// ***************************************************
	a_cfg_write: assert property (@(posedge clk) disable iff (!resetn) // [RULE_01]
		regWrEn && regAddr == CFG_ADDR |=> cfg_reg == $past(regWrData)) else $error("config write lost");

	a_disabled_quiet: assert property (@(posedge clk) disable iff (!resetn) // [RULE_02]
		!accelEnable |=> !extraIrq_reg) else $error("extra interrupt while disabled");

	a_limit_cap: assert property (@(posedge clk) disable iff (!resetn) // [RULE_04]
		state_reg == ST_SLIDE && !slideActive |=> extraLeft_reg <= $past(extraLimit))
		else $error("extras exceed limit");

	a_fast_full: assert property (@(posedge clk) disable iff (!resetn) // [RULE_05]
		state_reg == ST_SLIDE && !slideActive && accelEnable
		&& {1'b0, slideMs_reg, 1'b0} < {1'b0, sai_window_ms(windowSel)}
		|=> extraLeft_reg == $past(extraLimit)) else $error("fast slide not given full limit");

	a_slow_none: assert property (@(posedge clk) disable iff (!resetn) // [RULE_06]
		state_reg == ST_SLIDE && !slideActive && slideMs_reg > sai_window_ms(windowSel)
		|=> extraLeft_reg == 3'h0 && state_reg == ST_IDLE) else $error("slow slide earned extras");

	a_tick_paced: assert property (@(posedge clk) disable iff (!resetn) // [RULE_10]
		extraIrq_reg |-> $past(measTick)) else $error("interrupt not on measurement cycle");

	a_fast_interval: assert property (@(posedge clk) disable iff (!resetn) // [RULE_11]
		speedCount >= FAST_SENSORS |=> repeatInterval == RPT_CYC_35) else $error("fast interval wrong");

	a_strong_fixed: assert property (@(posedge clk) disable iff (!resetn) // [RULE_12]
		speedCount == 3'h2 && repeatScale == SCALE_STRONG |=> repeatInterval == RPT_CYC_140)
		else $error("strong scale not fixed");

	a_shared_path: assert property (@(posedge clk) disable iff (!resetn) // [RULE_13]
		extraIrq_reg |-> sliderIrq_reg) else $error("extra interrupt missing on slider path");

	a_input_path: assert property (@(posedge clk) disable iff (!resetn) // [RULE_13]
		slideIrqIn |=> sliderIrq_reg) else $error("ordinary interrupt lost");

	a_read_back: assert property (@(posedge clk) disable iff (!resetn) // [RULE_01]
		regRdEn && regAddr == CFG_ADDR |=> regRdData == $past(cfg_reg)) else $error("config read back wrong");

	a_end_disabled: assert property (@(posedge clk) disable iff (!resetn) // [RULE_02]
		state_reg == ST_SLIDE && !slideActive && !accelEnable |=> state_reg == ST_IDLE && extraLeft_reg == 3'h0)
		else $error("disabled slide left extras");

	a_pending_drop: assert property (@(posedge clk) disable iff (!resetn) // [RULE_02]
		state_reg == ST_EXTRA && !accelEnable |=> state_reg == ST_IDLE && extraLeft_reg == 3'h0)
		else $error("pending extras kept while disabled");

	a_new_slide: assert property (@(posedge clk) disable iff (!resetn) // [RULE_04]
		state_reg == ST_EXTRA && accelEnable && slideActive |=> state_reg == ST_SLIDE && extraLeft_reg == 3'h0)
		else $error("new slide kept old extras");

	// Band edges follow the count: half and three quarters strict, full window inclusive
	a_half_limit: assert property (@(posedge clk) disable iff (!resetn) // [RULE_05]
		state_reg == ST_SLIDE && !slideActive && accelEnable
		&& {1'b0, slideMs_reg, 1'b0} >= {2'h0, sai_window_ms(windowSel)}
		&& {slideMs_reg, 2'h0} < 12'(3 * sai_window_ms(windowSel))
		|=> extraLeft_reg == ($past(extraLimit) >> 1)) else $error("middle band count wrong");

	a_tail_one: assert property (@(posedge clk) disable iff (!resetn) // [RULE_05]
		state_reg == ST_SLIDE && !slideActive && accelEnable
		&& {slideMs_reg, 2'h0} >= 12'(3 * sai_window_ms(windowSel))
		&& slideMs_reg <= sai_window_ms(windowSel)
		|=> extraLeft_reg == (($past(extraLimit) >= LIMIT_HIGH) ? 3'h1 : 3'h0))
		else $error("tail band count wrong");

	// A due extra must leave on the next edge, else the interval drifts
	a_extra_issue: assert property (@(posedge clk) disable iff (!resetn) // [RULE_10]
		state_reg == ST_EXTRA && accelEnable && !slideActive && measTick && repCnt_reg <= 4'h1
		|=> extraIrq_reg && extraLeft_reg == $past(extraLeft_reg) - 3'h1) else $error("due extra not issued");

endmodule // sai_slider_accel

// File: design/sai_speed_meter.sv
// Counts sensor steps in each fixed speed window
module sai_speed_meter (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       resetn,
	// Timing and steps
	input  wire logic       msTick,
	input  wire logic       sensorStep,
	// Result
	output logic [2:0]      speedCount
);
	import sai_pkg::*;

	logic [6:0] winMs_reg;
	logic [6:0] winMs_next;
	logic [2:0] steps_reg;
	logic [2:0] steps_next;
	logic [2:0] speed_reg;
	logic [2:0] speed_next;
	logic [2:0] stepsInc;

	always_comb
	begin
		stepsInc   = (sensorStep && steps_reg != 3'h7) ? steps_reg + 3'h1 : steps_reg;
		winMs_next = winMs_reg;
		steps_next = stepsInc;
		speed_next = speed_reg;
		if (msTick)
		begin
			if (winMs_reg == SPEED_WIN_LAST) // [RULE_08]
			begin
				winMs_next = 7'h00;
				speed_next = stepsInc;
				steps_next = 3'h0;
			end
			else
				winMs_next = winMs_reg + 7'h01;
		end
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			winMs_reg <= 7'h00;
			steps_reg <= 3'h0;
			speed_reg <= 3'h0;
		end
		else
		begin
			winMs_reg <= winMs_next;
			steps_reg <= steps_next;
			speed_reg <= speed_next;
		end
	end

	assign speedCount = speed_reg;

	a_window_bound: assert property (@(posedge clk) disable iff (!resetn) // [RULE_08]
		winMs_reg <= SPEED_WIN_LAST) else $error("speed window overran");

endmodule // sai_speed_meter

// File: pkg/sai_pkg.sv
// Constants, state type and decode functions for the slider acceleration block
package sai_pkg;

	// ***************************************************
	// Timing
	// ***************************************************
	localparam int          CLK_HZ          = 40_000_000;
	localparam int          MS_PER_SEC      = 1000;
	localparam int          MS_CLOCKS       = CLK_HZ / MS_PER_SEC;
	localparam int          SPEED_WINDOW_MS = 100;
	localparam logic [6:0]  SPEED_WIN_LAST  = 7'(SPEED_WINDOW_MS - 1);
	localparam int          MEAS_CYCLE_MS   = 35;
	localparam logic [9:0]  SLIDE_MS_MAX    = 10'h3ff;

	// ***************************************************
	// Configuration register
	// ***************************************************
	localparam logic [7:0]  CFG_ADDR        = 8'h3e;
	localparam logic [7:0]  CFG_RESET       = 8'hc5;
	localparam int          ENABLE_BIT      = 7;
	localparam int          LIMIT_LSB       = 4;
	localparam int          WINDOW_LSB      = 2;
	localparam int          SCALE_LSB       = 0;
	localparam logic [1:0]  SCALE_STRONG    = 2'h3;

	// ***************************************************
	// Slide windows and repeat intervals
	// ***************************************************
	localparam logic [9:0]  WIN_MS_0        = 10'd350;
	localparam logic [9:0]  WIN_MS_1        = 10'd560;
	localparam logic [9:0]  WIN_MS_2        = 10'd770;
	localparam logic [9:0]  WIN_MS_3        = 10'd980;
	localparam int          RPT_MS_35       = 35;
	localparam int          RPT_MS_70       = 70;
	localparam int          RPT_MS_105      = 105;
	localparam int          RPT_MS_140      = 140;
	localparam logic [3:0]  RPT_CYC_35      = 4'(RPT_MS_35 / MEAS_CYCLE_MS);
	localparam logic [3:0]  RPT_CYC_70      = 4'(RPT_MS_70 / MEAS_CYCLE_MS);
	localparam logic [3:0]  RPT_CYC_105     = 4'(RPT_MS_105 / MEAS_CYCLE_MS);
	localparam logic [3:0]  RPT_CYC_140     = 4'(RPT_MS_140 / MEAS_CYCLE_MS);
	localparam logic [2:0]  FAST_SENSORS    = 3'h5;
	localparam logic [2:0]  LIMIT_HIGH      = 3'h4;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'h1,
		ST_SLIDE = 3'h2,
		ST_EXTRA = 3'h4
	} sai_state_t;

	// Window length in ms for the two-bit window field
	function automatic logic [9:0] sai_window_ms(input logic [1:0] sel);
		case (sel)
			2'h0:    return WIN_MS_0;
			2'h1:    return WIN_MS_1;
			2'h2:    return WIN_MS_2;
			default: return WIN_MS_3;
		endcase
	endfunction

	// Extra interrupts earned by a slide of t ms
	function automatic logic [2:0] sai_extra_count(input logic [9:0] t, input logic [1:0] sel,
		input logic [2:0] lim);
		logic [11:0] w;
		logic [11:0] t2;
		logic [11:0] t4;
		w  = {2'h0, sai_window_ms(sel)};
		t2 = {1'b0, t, 1'b0};
		t4 = {t, 2'h0};
		if (t2 < w)
			return lim;
		else if (t4 < 12'(3 * w))
			return lim >> 1;
		else if ({2'h0, t} <= w)
			return (lim >= LIMIT_HIGH) ? 3'h1 : 3'h0;
		else
			return 3'h0;
	endfunction

	// Measurement cycles between generated interrupts
	function automatic logic [3:0] sai_repeat_cycles(input logic [2:0] spd, input logic [1:0] scale,
		input logic [3:0] normal);
		logic [3:0] tab;
		tab = RPT_CYC_35;
		if (spd <= 3'h1)
			return normal;
		if (spd == 3'h4)
			tab = (scale == 2'h3) ? RPT_CYC_70 : RPT_CYC_35;
		else if (spd == 3'h3)
			tab = (scale == 2'h3) ? RPT_CYC_105 : (scale == 2'h2) ? RPT_CYC_70 : RPT_CYC_35;
		else if (spd == 3'h2)
			tab = (scale == 2'h3) ? RPT_CYC_140 : (scale == 2'h2) ? RPT_CYC_105 :
				(scale == 2'h1) ? RPT_CYC_70 : RPT_CYC_35;
		// Strongest scale keeps its fixed values even when normal is shorter
		if (scale != SCALE_STRONG && normal < tab && normal != 4'h0)
			return normal;
		return tab;
	endfunction

endpackage

// File: sim/sai_slider_accel_tb.sv
// Self-checking testbench for the slider acceleration block
module sai_slider_accel_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import sai_pkg::*;

	// ***************************************************
	// Setup
	// ***************************************************
	// Short ms so that a 100 ms speed window is 500 clocks
	localparam int MS_CLK  = 5;
	localparam int WIN_CLK = SPEED_WINDOW_MS * MS_CLK;
	// Slides and speed cases together take about 48k clocks
	localparam int LIMIT   = 70000;

	logic       clk;
	logic       resetn;
	logic [7:0] regAddr;
	logic       regWrEn;
	logic [7:0] regWrData;
	logic       regRdEn;
	logic [7:0] regRdData;
	logic       measTick;
	logic       slideActive;
	logic       sensorStep;
	logic       slideIrqIn;
	logic [3:0] sliderRepeatInterval;
	logic       sliderIrq;
	logic       extraIrq;
	logic [2:0] extraPending;
	logic [3:0] repeatInterval;
	int         failCount;
	int         testsRun;
	int         xCnt;
	int         sCnt;
	int         cycles;
	logic [7:0] rd;
	logic [7:0] sCfg [12];
	int         sMs [12];

	sai_slider_accel #(
		.MsClocks(MS_CLK)
	) u_dut (
		.clk                 (clk),
		.resetn              (resetn),
		.regAddr             (regAddr),
		.regWrEn             (regWrEn),
		.regWrData           (regWrData),
		.regRdEn             (regRdEn),
		.regRdData           (regRdData),
		.measTick            (measTick),
		.slideActive         (slideActive),
		.sensorStep          (sensorStep),
		.slideIrqIn          (slideIrqIn),
		.sliderRepeatInterval(sliderRepeatInterval),
		.sliderIrq           (sliderIrq),
		.extraIrq            (extraIrq),
		.extraPending        (extraPending),
		.repeatInterval      (repeatInterval)
	);

	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// Count pulses away from the edge that launches them
	always @(negedge clk)
	begin
		if (extraIrq === 1'b1)
			xCnt++;
		if (sliderIrq === 1'b1)
			sCnt++;
		cycles++;
		if (cycles == LIMIT)
		begin
			failCount++;
			results();
		end
	end

	// ***************************************************
	// Tasks
	// ***************************************************
	task automatic results();
		$display("checks %0d mismatches %0d", testsRun, failCount);
		if (failCount == 0 && testsRun > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		testsRun++;
		if (got !== exp)
		begin
			failCount++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic regWrite(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		regAddr   = a;
		regWrData = d;
		regWrEn   = 1'b1;
		@(negedge clk);
		regWrEn   = 1'b0;
	endtask

	task automatic regRead(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		regAddr = a;
		regRdEn = 1'b1;
		@(negedge clk);
		regRdEn = 1'b0;
		d       = regRdData;
	endtask

	// Expected extras, worked out from the window and limit fields
	function automatic logic [2:0] expExtra(input logic [7:0] c, input int t);
		int         w;
		logic [2:0] lim;
		w   = 350 + 210 * int'(c[3:2]);
		lim = c[6:4];
		if (!c[7])
			return 3'h0;
		if (2 * t < w)
			return lim;
		if (4 * t < 3 * w)
			return lim >> 1;
		if (t <= w)
			return (lim >= 3'h4) ? 3'h1 : 3'h0;
		return 3'h0;
	endfunction

	// Expected interval in 35 ms measurement cycles
	function automatic logic [3:0] expRpt(input int n, input int sc, input logic [3:0] nrm);
		int         d;
		logic [3:0] r;
		d = sc - (n - 2);
		if (n <= 1)
			return nrm;
		r = (n < 5 && d > 0) ? 4'(1 + d) : 4'h1;
		// Weaker scales fall back to a shorter normal interval
		if (sc != 3 && nrm != 4'h0 && nrm < r)
			return nrm;
		return r;
	endfunction

	// One slide of ms length, then measurement ticks to drain the extras
	task automatic slide(input int ms, input logic [2:0] expN);
		int x0;
		int s0;
		slideActive = 1'b1;
		tick(ms * MS_CLK);
		slideActive = 1'b0;
		tick(3);
		chk({5'h0, extraPending}, {5'h0, expN});
		x0 = xCnt;
		s0 = sCnt;
		repeat (12)
		begin
			measTick = 1'b1;
			tick(1);
			measTick = 1'b0;
			tick(3);
		end
		chk(8'(xCnt - x0), {5'h0, expN});
		chk(8'(sCnt - s0), {5'h0, expN});
		chk({5'h0, extraPending}, 8'h00);
	endtask

	// Bursts of n steps one window apart; checked mid third period, so the
	// last finished window lies wholly inside the periodic pattern
	task automatic speedCase(input int n, input int sc, input logic [3:0] nrm);
		sliderRepeatInterval = nrm;
		regWrite(CFG_ADDR, 8'hc4 | 8'(sc));
		for (int k = 0; k < 3; k++)
		begin
			repeat (n)
			begin
				sensorStep = 1'b1;
				tick(1);
				sensorStep = 1'b0;
				tick(1);
			end
			tick(((k == 2) ? WIN_CLK / 2 : WIN_CLK) - 2 * n);
		end
		chk({4'h0, repeatInterval}, {4'h0, expRpt(n, sc, nrm)});
	endtask

	// Repeat interrupts inside a slide, paced by a normal interval of 3 cycles
	task automatic inSlide(input logic [7:0] c, input logic [2:0] expN);
		int x0;
		int s0;
		regWrite(CFG_ADDR, c);
		sliderRepeatInterval = 4'h3;
		tick(2 * WIN_CLK);
		x0 = xCnt;
		s0 = sCnt;
		slideActive = 1'b1;
		tick(2);
		repeat (9)
		begin
			measTick = 1'b1;
			tick(1);
			measTick = 1'b0;
			tick(3);
		end
		slideActive = 1'b0;
		tick(3);
		chk(8'(xCnt - x0), {5'h0, expN});
		chk(8'(sCnt - s0), {5'h0, expN});
		chk({5'h0, extraPending}, 8'h00);
	endtask

	// ***************************************************
	// Main sequence
	// ***************************************************
	initial
	begin
		{resetn, regWrEn, regRdEn, measTick, slideActive, sensorStep, slideIrqIn} = '0;
		regAddr = 8'h00;
		regWrData = 8'h00;
		sliderRepeatInterval = 4'h1;
		sCfg = '{8'hc5, 8'hf1, 8'hf1, 8'hf1, 8'hf1, 8'hb1, 8'hb1, 8'hc9, 8'hcd, 8'hc5, 8'h45, 8'h81};
		sMs  = '{200, 100, 200, 315, 385, 100, 315, 600, 800, 520, 100, 100};
		tick(5);
		resetn = 1'b1;
		tick(2);
		regRead(CFG_ADDR, rd);
		chk(rd, 8'hc5);
		regRead(8'h3f, rd);
		chk(rd, 8'h00);
		regWrite(8'h3f, 8'hff);
		regRead(CFG_ADDR, rd);
		chk(rd, 8'hc5);
		regWrite(CFG_ADDR, 8'h5a);
		regRead(CFG_ADDR, rd);
		chk(rd, 8'h5a);
		slideIrqIn = 1'b1;
		tick(1);
		slideIrqIn = 1'b0;
		chk({7'h0, sliderIrq}, 8'h01);
		tick(1);
		chk({7'h0, sliderIrq}, 8'h00);
		for (int i = 0; i < 12; i++)
		begin
			regWrite(CFG_ADDR, sCfg[i]);
			slide(sMs[i], expExtra(sCfg[i], sMs[i]));
		end
		// Speed cases run inside one long slide, so it must end with no extras
		slideActive = 1'b1;
		for (int n = 5; n >= 1; n--)
			for (int sc = 0; sc < 4; sc++)
				speedCase(n, sc, 4'h8);
		speedCase(2, 3, 4'h2);
		speedCase(3, 3, 4'h2);
		speedCase(2, 2, 4'h2);
		slideActive = 1'b0;
		tick(3);
		chk({5'h0, extraPending}, 8'h00);
		inSlide(8'h87, 3'h3);
		inSlide(8'h07, 3'h0);
		results();
	end

endmodule // sai_slider_accel_tb
